// [rtl/usart_rx_pkg.sv]
package usart_rx_pkg;
   // Register byte addresses (printed offsets are not all multiples of four)
   localparam logic [7:0] IDX_INT_FLAGS = 8'h0C;
   localparam logic [7:0] IDX_RCV_STAT = 8'h18;
   localparam logic [7:0] IDX_TX_BUF = 8'h19;
   localparam logic [7:0] IDX_RCV_BUF = 8'h1A;
   localparam logic [7:0] IDX_INT_ENABLES = 8'h8C;
   localparam logic [7:0] IDX_TX_STAT = 8'h98;
   localparam logic [7:0] IDX_BAUD = 8'h99;
   // Word addresses (index times four)
   localparam logic [9:0] ADR_INT_FLAGS = {IDX_INT_FLAGS, 2'b00};
   localparam logic [9:0] ADR_RCV_STAT = {IDX_RCV_STAT, 2'b00};
   localparam logic [9:0] ADR_TX_BUF = {IDX_TX_BUF, 2'b00};
   localparam logic [9:0] ADR_RCV_BUF = {IDX_RCV_BUF, 2'b00};
   localparam logic [9:0] ADR_INT_ENABLES = {IDX_INT_ENABLES, 2'b00};
   localparam logic [9:0] ADR_TX_STAT = {IDX_TX_STAT, 2'b00};
   localparam logic [9:0] ADR_BAUD = {IDX_BAUD, 2'b00};
   // Receive status/control field positions
   localparam int RS_PORT_EN = 7;
   localparam int RS_NINE_SEL = 6;
   localparam int RS_SINGLE_EN = 5;
   localparam int RS_CONT_EN = 4;
   localparam int RS_ADDR_DET = 3;
   localparam int RS_FRAME_ERR = 2;
   localparam int RS_OVR_ERR = 1;
   localparam int RS_NINTH_BIT = 0;
   // Transmit status/control field positions
   localparam int TS_CLK_SRC = 7;
   localparam int TS_SYNC = 4;
   // Flag/enable position of the receive event
   localparam int PI_RCV = 5;
   // Reset values
   localparam logic [7:0] RST_TX_STAT = 8'h02;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // Writable mask of transmit status (bit 3 and bit 1 not writable)
   localparam logic [7:0] TX_STAT_WMASK = 8'hF5;
   // Interrupt vector taken on each received word with its enable and global interrupts on, asleep or not
   localparam logic [12:0] INT_VECTOR = 13'h0004;
endpackage : usart_rx_pkg

// [rtl/usart_sync_slave_receiver.sv]
// Our own choice: the Wishbone interface to the registers.
module usart_sync_slave_receiver
   import usart_rx_pkg::*;
(
   input wire logic mclk_in, // Core clock
   input wire logic arst_n_in, // Async reset, active low
   input wire logic [31:0] wb_adr_in, // Wishbone address
   input wire logic [31:0] wb_dat_in, // Write data
   input wire logic [3:0] wb_sel_in, // Byte selects
   input wire logic wb_we_in, // Write strobe
   input wire logic wb_cyc_in, // Cycle
   input wire logic wb_stb_in, // Strobe
   output logic [31:0] wb_dat_out, // Read data
   output logic wb_ack_out, // Acknowledge
   input wire logic shift_clk_in, // Shift clock from master
   input wire logic serial_data_in, // Data line
   input wire logic sleep_in, // Core asleep
   input wire logic global_int_enable_in, // Core global interrupt enable
   output logic irq_out, // Level interrupt
   output logic wake_out, // Wake request to core
   output logic vector_jump_out, // One pulse: branch to vector
   output logic [12:0] vector_addr_out // Vector address
);
   import usart_rx_pkg::*;

   // Register state
   logic [7:0] flags; // Peripheral flags (sticky)
   logic [7:0] enables; // Peripheral enables / mask
   logic [7:0] rcv_ctrl; // Control bits 7..3 of receive status
   logic frame_err, ovr_err, ninth; // Status bits
   logic [7:0] rcv_buf; // Receive buffer
   logic buf_full; // Buffer unread
   logic [7:0] tx_buf, tx_stat, baud; // tx_buf and baud storage only; tx_stat also selects mode
   logic [8:0] shreg; // Receive shift register
   logic [3:0] bit_cnt; // Bits shifted so far
   logic [2:0] clk_sync, dat_sync; // Two-flop sync plus edge history
   logic ack;
   logic [31:0] rdata;
   logic irq, wake, vjump;
   // Next values
   logic [7:0] next_flags, next_enables, next_rcv_ctrl, next_rcv_buf;
   logic next_frame_err, next_ovr_err, next_ninth, next_buf_full;
   logic [7:0] next_tx_buf, next_tx_stat, next_baud;
   logic [8:0] next_shreg;
   logic [3:0] next_bit_cnt;
   logic next_ack, next_irq, next_wake, next_vjump;
   logic [31:0] next_rdata;
   // Decoded controls
   logic slave_mode, rx_on, fall, word_done, acc, wr, rd;
   logic [3:0] word_len;
   logic [8:0] shifted;

   // Address match of one register word
   function automatic logic hit(input logic [31:0] a, input logic [9:0] r);
      hit = (a[31:10] == 22'h0) && (a[9:0] == r);
   endfunction : hit

   // Synchronisers; bit 0 is first stage and read only by bit 1
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         clk_sync <= 3'h0;
         dat_sync <= 3'h0;
      end else begin
         clk_sync <= {clk_sync[1:0], shift_clk_in};
         dat_sync <= {dat_sync[1:0], serial_data_in};
      end
   end

   // Mode and receive decode
   always_comb begin
      // Sync slave: sync on, port on, clock external
      slave_mode = tx_stat[TS_SYNC] & rcv_ctrl[RS_PORT_EN] & ~tx_stat[TS_CLK_SRC];
      // Only continuous enable matters; single enable ignored
      rx_on = slave_mode & rcv_ctrl[RS_CONT_EN] & ~ovr_err;
      // Falling edge of synchronised shift clock
      fall = clk_sync[2] & ~clk_sync[1];
      word_len = rcv_ctrl[RS_NINE_SEL] ? 4'h9 : 4'h8;
      // LSB first into the top of the word
      shifted = rcv_ctrl[RS_NINE_SEL] ? {dat_sync[1], shreg[8:1]} :
         {1'b0, dat_sync[1], shreg[7:1]};
      word_done = rx_on & fall & (bit_cnt == word_len - 4'h1);
      acc = wb_cyc_in & wb_stb_in & ~ack;
      // Write lands at the edge where the master samples ack high
      wr = wb_cyc_in & wb_stb_in & ack & wb_we_in & wb_sel_in[0];
      rd = acc & ~wb_we_in;
   end

   // Next-state: shifter, buffer, registers and bus
   always_comb begin
      next_shreg = shreg;
      next_bit_cnt = bit_cnt;
      next_rcv_buf = rcv_buf;
      next_buf_full = buf_full;
      next_ninth = ninth;
      next_frame_err = frame_err;
      next_ovr_err = ovr_err;
      next_flags = flags;
      next_enables = enables;
      next_rcv_ctrl = rcv_ctrl;
      next_tx_buf = tx_buf;
      next_tx_stat = tx_stat;
      next_baud = baud;
      next_rdata = 32'h0;
      next_ack = acc;
      // Shift on each falling clock edge, works during sleep
      if (!rx_on) begin
         next_bit_cnt = 4'h0;
      end else if (fall) begin
         next_shreg = shifted;
         next_bit_cnt = word_done ? 4'h0 : bit_cnt + 4'h1;
      end
      // Buffer read by software frees the slot
      if (rd && hit(wb_adr_in, ADR_RCV_BUF)) begin
         next_buf_full = 1'b0;
      end
      // Flags register read clears sticky flags
      if (rd && hit(wb_adr_in, ADR_INT_FLAGS)) begin
         next_flags = 8'h00;
      end
      // Word complete: transfer or overrun
      if (word_done) begin
         if (buf_full && !(rd && hit(wb_adr_in, ADR_RCV_BUF))) begin
            next_ovr_err = 1'b1;
         end else begin
            next_rcv_buf = shifted[7:0];
            next_ninth = rcv_ctrl[RS_NINE_SEL] & shifted[8];
            next_buf_full = 1'b1;
         end
         // Event set wins over read-clear
         next_flags[PI_RCV] = 1'b1;
      end
      // Register writes
      if (wr) begin
         if (hit(wb_adr_in, ADR_RCV_STAT)) begin
            next_rcv_ctrl = wb_dat_in[7:0] & 8'hF8;
            // Clearing continuous enable clears errors
            if (!wb_dat_in[RS_CONT_EN]) begin
               next_ovr_err = 1'b0;
               next_frame_err = 1'b0;
            end
         end
         if (hit(wb_adr_in, ADR_INT_ENABLES)) next_enables = wb_dat_in[7:0];
         if (hit(wb_adr_in, ADR_TX_BUF)) next_tx_buf = wb_dat_in[7:0];
         if (hit(wb_adr_in, ADR_BAUD)) next_baud = wb_dat_in[7:0];
         if (hit(wb_adr_in, ADR_TX_STAT)) begin
            next_tx_stat = (wb_dat_in[7:0] & TX_STAT_WMASK) | (tx_stat & ~TX_STAT_WMASK);
         end
      end
      // Read data; unmapped and unimplemented bits read zero
      if (rd) begin
         if (hit(wb_adr_in, ADR_INT_FLAGS)) next_rdata = {24'h0, flags};
         else if (hit(wb_adr_in, ADR_RCV_STAT)) begin
            next_rdata = {24'h0, rcv_ctrl[7:3], frame_err, ovr_err, ninth};
         end else if (hit(wb_adr_in, ADR_RCV_BUF)) next_rdata = {24'h0, rcv_buf};
         else if (hit(wb_adr_in, ADR_INT_ENABLES)) next_rdata = {24'h0, enables};
         else if (hit(wb_adr_in, ADR_TX_STAT)) next_rdata = {24'h0, tx_stat};
         else if (hit(wb_adr_in, ADR_BAUD)) next_rdata = {24'h0, baud};
         else next_rdata = 32'h0;
      end
      // Interrupt, wake and vector jump
      next_irq = |(next_flags & enables);
      next_wake = sleep_in & word_done & enables[PI_RCV];
      next_vjump = word_done & enables[PI_RCV] & global_int_enable_in;
   end

   // Register all state
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         shreg <= 9'h0;
         bit_cnt <= 4'h0;
         rcv_buf <= RST_ZERO;
         buf_full <= 1'b0;
         ninth <= 1'b0;
         frame_err <= 1'b0;
         ovr_err <= 1'b0;
         flags <= RST_ZERO;
         enables <= RST_ZERO;
         rcv_ctrl <= RST_ZERO;
         tx_buf <= RST_ZERO;
         tx_stat <= RST_TX_STAT;
         baud <= RST_ZERO;
         rdata <= 32'h0;
         ack <= 1'b0;
         irq <= 1'b0;
         wake <= 1'b0;
         vjump <= 1'b0;
      end else begin
         shreg <= next_shreg;
         bit_cnt <= next_bit_cnt;
         rcv_buf <= next_rcv_buf;
         buf_full <= next_buf_full;
         ninth <= next_ninth;
         frame_err <= next_frame_err;
         ovr_err <= next_ovr_err;
         flags <= next_flags;
         enables <= next_enables;
         rcv_ctrl <= next_rcv_ctrl;
         tx_buf <= next_tx_buf;
         tx_stat <= next_tx_stat;
         baud <= next_baud;
         rdata <= next_rdata;
         ack <= next_ack;
         irq <= next_irq;
         wake <= next_wake;
         vjump <= next_vjump;
      end
   end

   // Outputs straight from flops; vector address is a constant
   assign wb_dat_out = rdata;
   assign wb_ack_out = ack;
   assign irq_out = irq;
   assign wake_out = wake;
   assign vector_jump_out = vjump;
   assign vector_addr_out = INT_VECTOR;

   // Completed word lands in buffer next cycle
   chk_word_to_buf: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      word_done && !buf_full |=> buf_full && rcv_buf == $past(shifted[7:0]))
      else $error("word not moved to buffer");
   // Flag set after completion
   chk_flag_set: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      word_done |=> flags[PI_RCV])
      else $error("receive flag not set");
   // Interrupt follows enabled flag within two cycles
   chk_irq_level: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      word_done && enables[PI_RCV] |=> ##[0:1] irq_out)
      else $error("interrupt missing");
   // Overrun on unread buffer
   chk_overrun: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      word_done && buf_full && !rd |=> ovr_err)
      else $error("overrun not flagged");
   // Single enable alone receives nothing
   chk_single_ignored: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      !rcv_ctrl[RS_CONT_EN] |-> !word_done)
      else $error("reception without continuous enable");
   // Clearing continuous enable clears overrun
   chk_err_clear: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      wr && hit(wb_adr_in, ADR_RCV_STAT) && !wb_dat_in[RS_CONT_EN] |=>
      !ovr_err && !frame_err)
      else $error("error not cleared");
   // Ninth bit captured with the word
   chk_ninth_bit: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      word_done && !buf_full && rcv_ctrl[RS_NINE_SEL] |=> ninth == $past(shifted[8]))
      else $error("ninth bit wrong");
   // Shift only on falling edges
   chk_fall_shift: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      rx_on && !fall |=> $stable(shreg))
      else $error("shift without falling edge");
   // Unmapped read answers zero
   chk_unmapped_zero: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      rd && wb_adr_in[31:10] != 22'h0 |=> wb_ack_out && wb_dat_out == 32'h0)
      else $error("unmapped read not zero");
endmodule : usart_sync_slave_receiver

// [sim/link_master.sv]
// Far-side synchronous master: drives shift clock and data
module link_master (
   input wire logic go_in, // Start one frame
   input wire logic [8:0] word_in, // Frame bits, LSB first
   input wire logic [3:0] nbits_in, // Bits in frame
   output logic sck_out, // Shift clock, still low between frames
   output logic sdat_out, // Data line
   output logic busy_out // Frame in progress
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sck_out = 1'b0;
      sdat_out = 1'b0;
      busy_out = 1'b0;
   end
   // One frame at 125 ns per bit; data steady across each fall
   always @(posedge go_in) begin
      busy_out = 1'b1;
      for (int i = 0; i < nbits_in; i++) begin
         sdat_out = word_in[i];
         #31.25 sck_out = 1'b1;
         #62.5 sck_out = 1'b0;
         #31.25;
      end
      // Line released: no pull, so show the inverse
      sdat_out = ~sdat_out;
      busy_out = 1'b0;
   end
endmodule : link_master

// [sim/usart_sync_slave_receiver_tb.sv]
module usart_sync_slave_receiver_tb;
   import usart_rx_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in = 0, arst_n_in = 0, wb_we_in = 0, wb_cyc_in = 0, wb_stb_in = 0;
   logic [31:0] wb_adr_in = 0, wb_dat_in = 0, wb_dat_out;
   logic [3:0] wb_sel_in = 4'hF;
   logic wb_ack_out, irq_out, wake_out, vector_jump_out, sck, sdat, busy;
   logic sleep_in = 0, gie = 0, go = 0;
   logic [12:0] vector_addr_out;
   logic [8:0] word = 0;
   logic [3:0] nbits = 0;
   int err_count = 0, comparisons = 0, wakes = 0, jumps = 0;
   // Core clock, 4 ns period
   always #2 mclk_in = ~mclk_in;
   usart_sync_slave_receiver u_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
      .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in), .wb_sel_in(wb_sel_in),
      .wb_we_in(wb_we_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
      .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .shift_clk_in(sck),
      .serial_data_in(sdat), .sleep_in(sleep_in), .global_int_enable_in(gie),
      .irq_out(irq_out), .wake_out(wake_out), .vector_jump_out(vector_jump_out),
      .vector_addr_out(vector_addr_out));
   link_master u_link (.go_in(go), .word_in(word), .nbits_in(nbits),
      .sck_out(sck), .sdat_out(sdat), .busy_out(busy));
   // Count wake and vector pulses
   always @(posedge mclk_in) begin
      if (wake_out === 1'b1) wakes++;
      if (vector_jump_out === 1'b1) jumps++;
   end
   task results;
      if (err_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         err_count++;
      end
   endtask : chk
   // Classic Wishbone single cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d,
         output logic [7:0] q);
      int n;
      n = 0;
      @(posedge mclk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= we;
      wb_adr_in <= {22'h0, a};
      wb_dat_in <= {24'h0, d};
      do begin
         @(posedge mclk_in);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 50);
      if (n == 50) begin
         err_count++;
         results();
      end else begin
         q = wb_dat_out[7:0];
         wb_cyc_in <= 1'b0;
         wb_stb_in <= 1'b0;
         wb_we_in <= 1'b0;
      end
   endtask : wb
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask : rd
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   // Send one frame and wait for it to end, then let the sync settle
   task automatic send(input logic [8:0] w, input logic [3:0] n);
      int k;
      k = 0;
      @(posedge mclk_in);
      word <= w;
      nbits <= n;
      go <= 1'b1;
      @(posedge mclk_in);
      go <= 1'b0;
      do begin
         @(posedge mclk_in);
         k++;
      end while (busy !== 1'b0 && k < 1000);
      if (k == 1000) begin
         err_count++;
         results();
      end else repeat (8) @(posedge mclk_in);
   endtask : send
   task reset_values;
      rd(10'h030, 8'h00);
      rd(ADR_RCV_STAT, 8'h00);
      rd(ADR_RCV_BUF, 8'h00);
      rd(10'h230, 8'h00);
      rd(ADR_TX_STAT, RST_TX_STAT);
      rd(ADR_BAUD, 8'h00);
      rd(10'h3FC, 8'h00);
   endtask : reset_values
   task rx_basic;
      wr(ADR_TX_STAT, 8'h10);
      wr(ADR_RCV_STAT, 8'hB0);
      send(9'h0A5, 4'd8);
      chk(irq_out, 1'b0);
      rd(10'h030, 8'h20);
      rd(ADR_RCV_STAT, 8'hB0);
      rd(ADR_RCV_BUF, 8'hA5);
      wr(10'h230, 8'h20);
      send(9'h05A, 4'd8);
      chk(irq_out, 1'b1);
      rd(10'h030, 8'h20);
      repeat (3) @(posedge mclk_in);
      chk(irq_out, 1'b0);
      rd(ADR_RCV_BUF, 8'h5A);
   endtask : rx_basic
   task rx_sleep;
      wr(ADR_RCV_STAT, 8'hD0);
      sleep_in <= 1'b1;
      gie <= 1'b1;
      send(9'h13C, 4'd9);
      sleep_in <= 1'b0;
      chk(wakes, 1);
      chk(jumps, 1);
      chk(vector_addr_out, 13'h0004);
      rd(ADR_RCV_STAT, 8'hD1);
      rd(ADR_RCV_BUF, 8'h3C);
      rd(10'h030, 8'h20);
   endtask : rx_sleep
   task rx_overrun;
      send(9'h011, 4'd9);
      send(9'h022, 4'd9);
      rd(ADR_RCV_STAT, 8'hD2);
      rd(ADR_RCV_BUF, 8'h11);
      wr(ADR_RCV_STAT, 8'hC0);
      rd(ADR_RCV_STAT, 8'hC0);
   endtask : rx_overrun
   initial begin
      repeat (10) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      reset_values();
      rx_basic();
      rx_sleep();
      rx_overrun();
      results();
   end
endmodule : usart_sync_slave_receiver_tb
